// ===== rtl/lod_params.svh
// Constants of the electrode lead-off detector: register map, field positions,
// reset values, comparator levels and timing counts.
// Assumes a 100 MHz system clock.
`ifndef LOD_PARAMS_SVH
`define LOD_PARAMS_SVH

`define LOD_CLK_PERIOD_NS 10
// Register addresses
`define LOD_ADDR_CTL 6'h02
`define LOD_ADDR_UTH 6'h03
`define LOD_ADDR_LTH 6'h04
`define LOD_ADDR_DCSTAT 6'h1e
`define LOD_ADDR_LEAD_OFF_STATUS_REG 6'h1f
`define LOD_ADDR_AMP_FIRST 6'h31
`define LOD_ADDR_AMP_LAST 6'h35
// lead_off_control fields
`define LOD_CTL_DC_EN 0
`define LOD_CTL_AC_EN 1
`define LOD_CTL_CUR 4:2
`define LOD_CTL_AMP 17:16
`define LOD_CTL_POL 23:18
`define LOD_CUR_MAX 3'h6
// Threshold register fields
`define LOD_TH_AC 15:0
`define LOD_TH_ADC 23:16
// Reset values
`define LOD_CTL_RST 24'h000000
`define LOD_UTH_RST 24'h7fffff
`define LOD_LTH_RST 24'h800000
// Fixed dc comparator levels in mV
`define LOD_DC_HI_MV 12'h960
`define LOD_DC_LO_MV 12'h0c8
`define LOD_REF_HI_MV 12'hb54
`define LOD_REF_LO_MV 12'h064
// Carrier 2.039 kHz as phase step of a 32-bit accumulator
`define LOD_CARRIER_HZ 2039
`define LOD_PHASE_INC \
  (32'((64'd`LOD_CARRIER_HZ << 32) * `LOD_CLK_PERIOD_NS / 64'd1000000000))
// Detection latency under 10 ms; amplitude window 1 ms
`define LOD_LATENCY_MS 10
`define LOD_WIN_NS 1000000
`define LOD_WIN_CYCLES (`LOD_WIN_NS / `LOD_CLK_PERIOD_NS)

`endif

// ===== rtl/lod_pkg.sv
// Types shared by the lead-off detector files.
// Assumes nothing beyond the constants header.
package lod_pkg;
  typedef logic [11:0] lod_mv_t;
  typedef logic [15:0] lod_smp_t;
  typedef struct packed {
    logic lead_off;
    logic adc_oor;
  } lod_hdr_s;
endpackage

// ===== rtl/lod_amp_mem.sv
// Eight-word amplitude store with registered read data.
// Assumes one writer and one reader in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module lod_amp_mem (
  input wire logic clk_i, // System clock
  input wire logic we_i, // Write strobe
  input wire logic [2:0] waddr_i, // Write index
  input wire logic [23:0] wdata_i, // Write word
  input wire logic [2:0] raddr_i, // Read index
  output logic [23:0] rdata_o // Registered read word
);
  logic [23:0] mem [0:7];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // lod_amp_mem
`default_nettype wire

// ===== rtl/lod_top.sv
// Lead-off detector: dc comparators, ac carrier demodulation, ADC range
// check, frame header flags and the register port.
// Assumes pin levels arrive digitised in mV and all inputs are synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "lod_params.svh"

// Functional notes
// - DC flag above 2.4 V or below 0.2 V
// - DC current 10 to 70 nA, 10 nA steps
// - All six inputs share dc detection, own bit
// - Reference saturation flagged in dc status register
// - AC carrier fixed at 2.039 kHz
// - Per-electrode polarity bits 23:18, programmable amplitude
// - AC only on three limbs and common-mode
// - I/Q demodulate, amplitude detect, low-pass filter
// - AC flag when amplitude above upper threshold
// - AC flag when amplitude below lower threshold
// - Compare gain-scaled amplitude, current-independent thresholds
// - Amplitudes readable at four consecutive registers
// - AC lead-off reported within 10 ms
// - AC detection off while calibration DAC enabled
// - ADC range check sets header flag
// - Any lead-off sets header lead-off flag
// - DC and AC methods enabled independently
module lod_top import lod_pkg::*; #(
  parameter int unsigned WIN_CYCLES = `LOD_WIN_CYCLES
) (
  input wire logic REF_CLK_I, // System clock
  input wire logic SYS_RST_I, // Sync reset, high
  input wire logic REG_WR_I, // Register write strobe
  input wire logic REG_RD_I, // Register read strobe
  input wire logic [5:0] REG_ADDR_I, // Register address
  input wire logic [23:0] REG_WDATA_I, // Write data
  output logic [23:0] REG_RDATA_O, // Read data
  output logic REG_RVALID_O, // Read data valid pulse
  input wire lod_mv_t [6:0] ELEC_MV_I, // Pin levels RA LA LL V1 V2 CM REF
  input wire lod_smp_t [3:0] ADC_SMP_I, // Samples LA LL RA CM
  input wire logic SMP_VALID_I, // Sample strobe
  input wire logic CAL_DAC_EN_I, // Calibration DAC on
  input wire logic FRAME_I, // Frame boundary pulse
  output logic DC_EN_O, // DC current enable
  output logic [2:0] DC_CUR_O, // Current step, (n+1)*10 nA
  output logic [5:0] AC_DRIVE_O, // Carrier per electrode
  output logic [1:0] AC_AMP_O, // Drive amplitude code
  output lod_hdr_s HDR_O // Frame header flags
);
  localparam logic [31:0] PHASE_INC = `LOD_PHASE_INC;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] abs32(input logic signed [31:0] x);
    return x[31] ? 32'(-x) : 32'(x);
  endfunction

  function automatic logic [15:0] sat16(input logic [23:0] f);
    return (|f[23:16]) ? 16'hffff : f[15:0];
  endfunction

  function automatic logic out_of(input lod_mv_t v, input lod_mv_t hi,
                                  input lod_mv_t lo);
    return (v > hi) || (v < lo);
  endfunction

  function automatic logic adc_oor(input lod_smp_t s, input logic [23:0] u,
                                   input logic [23:0] l);
    return ($signed(s[15:8]) > $signed(u[`LOD_TH_ADC])) ||
           ($signed(s[15:8]) < $signed(l[`LOD_TH_ADC]));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [23:0] ctl, next_ctl;
  logic [23:0] uth, next_uth;
  logic [23:0] lth, next_lth;

  always_comb begin
    next_ctl = ctl;
    next_uth = uth;
    next_lth = lth;
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        `LOD_ADDR_CTL: begin
          next_ctl = REG_WDATA_I;
          if (REG_WDATA_I[`LOD_CTL_CUR] > `LOD_CUR_MAX) begin
            next_ctl[`LOD_CTL_CUR] = `LOD_CUR_MAX;
          end
        end
        `LOD_ADDR_UTH: next_uth = REG_WDATA_I;
        `LOD_ADDR_LTH: next_lth = REG_WDATA_I;
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      ctl <= `LOD_CTL_RST;
      uth <= `LOD_UTH_RST;
      lth <= `LOD_LTH_RST;
    end else begin
      ctl <= next_ctl;
      uth <= next_uth;
      lth <= next_lth;
    end
  end

  logic dc_en;
  logic ac_act;
  assign dc_en = ctl[`LOD_CTL_DC_EN];
  assign ac_act = ctl[`LOD_CTL_AC_EN] && !CAL_DAC_EN_I;

  //////////////////////////////////////////////////////////////////////////
  // DC comparators
  logic [6:0] dc_stat, next_dc_stat;

  always_comb begin
    next_dc_stat = '0;
    // same window on all six electrode pins, REF has its own
    for (int k = 0; k < 6; k++) begin
      next_dc_stat[k] = dc_en && out_of(ELEC_MV_I[k], `LOD_DC_HI_MV, `LOD_DC_LO_MV);
    end
    next_dc_stat[6] = dc_en && out_of(ELEC_MV_I[6], `LOD_REF_HI_MV, `LOD_REF_LO_MV);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      dc_stat <= '0;
    end else begin
      dc_stat <= next_dc_stat;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Carrier and drive outputs
  logic [31:0] phase, next_phase;
  logic [5:0] next_drive;

  always_comb begin
    next_phase = phase + PHASE_INC;
    next_drive = ac_act ? ({6{phase[31]}} ^ ctl[`LOD_CTL_POL]) : 6'h00;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      phase <= '0;
      AC_DRIVE_O <= '0;
      AC_AMP_O <= '0;
      DC_EN_O <= 1'b0;
      DC_CUR_O <= '0;
    end else begin
      phase <= next_phase;
      AC_DRIVE_O <= next_drive;
      AC_AMP_O <= ctl[`LOD_CTL_AMP];
      DC_EN_O <= dc_en;
      DC_CUR_O <= ctl[`LOD_CTL_CUR];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AC demodulation; the square-wave reference trades harmonic rejection
  // for having no multiplier
  logic signed [31:0] i_acc [4];
  logic signed [31:0] q_acc [4];
  logic signed [31:0] next_i [4];
  logic signed [31:0] next_q [4];
  logic [23:0] filt [4];
  logic [23:0] next_filt [4];
  logic [3:0] ac_flag, next_ac_flag;
  logic [16:0] win_cnt, next_win_cnt;
  logic dump;
  logic [2:0] sweep, next_sweep;

  assign dump = (win_cnt == 17'(WIN_CYCLES - 1));

  always_comb begin
    logic [32:0] mag;
    logic [25:0] d;
    logic signed [31:0] x;
    mag = '0;
    d = '0;
    x = '0;
    next_win_cnt = (dump || !ac_act) ? 17'h00000 : win_cnt + 17'h00001;
    next_sweep = dump ? 3'h4 : ((sweep != 3'h0) ? sweep - 3'h1 : 3'h0);
    for (int k = 0; k < 4; k++) begin
      next_i[k] = i_acc[k];
      next_q[k] = q_acc[k];
      next_filt[k] = filt[k];
      x = 32'($signed(ADC_SMP_I[k]));
      if (!ac_act || dump) begin
        next_i[k] = '0;
        next_q[k] = '0;
      end else if (SMP_VALID_I) begin
        next_i[k] = (phase[31] ^ phase[30]) ? i_acc[k] - x : i_acc[k] + x;
        next_q[k] = phase[31] ? q_acc[k] - x : q_acc[k] + x;
      end
      if (!ac_act) begin
        next_filt[k] = '0;
      end else if (dump) begin
        mag = {1'b0, abs32(i_acc[k])} + {1'b0, abs32(q_acc[k])};
        d = {2'b00, mag[32:9]} - {2'b00, filt[k]};
        next_filt[k] = filt[k] + 24'($signed(d) >>> 2);
      end
      next_ac_flag[k] = ac_act &&
        ((sat16(filt[k]) > uth[`LOD_TH_AC]) || (sat16(filt[k]) < lth[`LOD_TH_AC]));
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      win_cnt <= '0;
      sweep <= '0;
      ac_flag <= '0;
      for (int k = 0; k < 4; k++) begin
        i_acc[k] <= '0;
        q_acc[k] <= '0;
        filt[k] <= '0;
      end
    end else begin
      win_cnt <= next_win_cnt;
      sweep <= next_sweep;
      ac_flag <= next_ac_flag;
      for (int k = 0; k < 4; k++) begin
        i_acc[k] <= next_i[k];
        q_acc[k] <= next_q[k];
        filt[k] <= next_filt[k];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Amplitude store, refreshed one word a cycle after each window
  logic [2:0] mem_raddr;
  logic [23:0] mem_rdata;
  logic [1:0] sw_idx;

  assign sw_idx = 2'(sweep - 3'h1);
  assign mem_raddr = 3'(REG_ADDR_I - `LOD_ADDR_AMP_FIRST);

  lod_amp_mem u_amp (
    .clk_i(REF_CLK_I),
    .we_i(sweep != 3'h0),
    .waddr_i({1'b0, sw_idx}),
    .wdata_i(filt[sw_idx]),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Frame header; range hits are held until the next frame boundary
  logic oor_pend, next_oor_pend;
  lod_hdr_s next_hdr;
  logic any_oor;

  always_comb begin
    any_oor = 1'b0;
    for (int k = 0; k < 4; k++) begin
      any_oor = any_oor || (SMP_VALID_I && adc_oor(ADC_SMP_I[k], uth, lth));
    end
    // New hit in the frame cycle survives the clear
    next_oor_pend = FRAME_I ? any_oor : (oor_pend || any_oor);
    next_hdr = HDR_O;
    if (FRAME_I) begin
      next_hdr.lead_off = (|dc_stat) || (|ac_flag);
      next_hdr.adc_oor = oor_pend || any_oor;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      oor_pend <= 1'b0;
      HDR_O <= '0;
    end else begin
      oor_pend <= next_oor_pend;
      HDR_O <= next_hdr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads, two cycles to match the store's read register
  logic rd_v1, next_rd_v1;
  logic rd_mem1, next_rd_mem1;
  logic [23:0] rd_dat1, next_rd_dat1;
  logic [23:0] next_rdata;

  always_comb begin
    next_rd_v1 = REG_RD_I;
    next_rd_mem1 = 1'b0;
    next_rd_dat1 = '0;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `LOD_ADDR_CTL: next_rd_dat1 = ctl;
        `LOD_ADDR_UTH: next_rd_dat1 = uth;
        `LOD_ADDR_LTH: next_rd_dat1 = lth;
        `LOD_ADDR_DCSTAT: next_rd_dat1 = {17'h00000, dc_stat};
        `LOD_ADDR_LEAD_OFF_STATUS_REG: next_rd_dat1 = {13'h0000, ac_flag, dc_stat};
        // amplitude block, last word reads zero
        6'h31, 6'h32, 6'h33, 6'h34: next_rd_mem1 = 1'b1;
        default: next_rd_dat1 = '0;
      endcase
    end
    next_rdata = rd_mem1 ? mem_rdata : rd_dat1;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      rd_v1 <= 1'b0;
      rd_mem1 <= 1'b0;
      rd_dat1 <= '0;
      REG_RVALID_O <= 1'b0;
      REG_RDATA_O <= '0;
    end else begin
      rd_v1 <= next_rd_v1;
      rd_mem1 <= next_rd_mem1;
      rd_dat1 <= next_rd_dat1;
      REG_RVALID_O <= rd_v1;
      REG_RDATA_O <= rd_v1 ? next_rdata : 24'h000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_dc_window: assert property (
    dc_en && out_of(ELEC_MV_I[2], `LOD_DC_HI_MV, `LOD_DC_LO_MV) |=> dc_stat[2])
    else $error("dc window miss");
  a_dc_quiet: assert property (
    !dc_en |=> dc_stat == 7'h00)
    else $error("dc flag while disabled");
  a_cur_range: assert property (
    DC_CUR_O <= `LOD_CUR_MAX)
    else $error("current step out of range");
  a_ref_sat: assert property (
    dc_en && out_of(ELEC_MV_I[6], `LOD_REF_HI_MV, `LOD_REF_LO_MV) |=> dc_stat[6])
    else $error("reference saturation missed");
  a_ac_pol: assert property (
    ac_act |=> (AC_DRIVE_O ^ {6{AC_DRIVE_O[0]}}) ==
               ($past(ctl[`LOD_CTL_POL]) ^ {6{$past(ctl[18])}}))
    else $error("polarity pattern wrong");
  a_ac_upper: assert property (
    ac_act && sat16(filt[0]) > uth[`LOD_TH_AC] |=> ac_flag[0])
    else $error("upper threshold missed");
  a_carrier_step: assert property (
    !$past(SYS_RST_I) |-> phase == 32'($past(phase) + PHASE_INC))
    else $error("carrier step wrong");
  a_ac_lower: assert property (
    ac_act && sat16(filt[3]) < lth[`LOD_TH_AC] |=> ac_flag[3])
    else $error("lower threshold missed");
  a_cal_off: assert property (
    CAL_DAC_EN_I |=> ac_flag == 4'h0 && AC_DRIVE_O == 6'h00)
    else $error("ac active during calibration");
  a_win_bound: assert property (
    win_cnt < 17'(WIN_CYCLES))
    else $error("window overrun");
  a_hdr_lead: assert property (
    FRAME_I && (|dc_stat || |ac_flag) |=> HDR_O.lead_off)
    else $error("header lead-off missed");
  a_oor_hold: assert property (
    oor_pend && !FRAME_I |=> oor_pend)
    else $error("range hit lost");
  // Exact two-cycle answer, also for back-to-back reads
  a_rd_latency: assert property (
    REG_RVALID_O == $past(REG_RD_I, 2))
    else $error("read latency wrong");

  c_dc_off: cover property (dc_stat[2] ##1 FRAME_I);
  c_ac_off: cover property (ac_flag[0] && !dc_en);
  c_oor: cover property (FRAME_I && oor_pend);
  c_amp_rd: cover property (REG_RD_I && REG_ADDR_I == `LOD_ADDR_AMP_FIRST);
endmodule // lod_top
`default_nettype wire

// ===== test/lod_electrodes.sv
// Patient electrode and cable model: ADC samples of the injected carrier.
// Assumes the bench picks which electrodes float and the sample offset.
`timescale 1ns/1ps
`default_nettype none
module lod_electrodes import lod_pkg::*; (
  input wire logic clk_i, // System clock
  input wire logic [5:0] drive_i, // Carrier per electrode
  input wire logic [3:0] float_i, // Electrode off, per ADC channel
  input wire logic [15:0] base_i, // Common offset of samples
  output lod_smp_t [3:0] smp_o, // Samples LA LL RA CM
  output logic valid_o // Sample strobe
);
  // Drive bit feeding each ADC channel: LA LL RA CM
  localparam logic [2:0] DRV_MAP [4] = '{3'h1, 3'h2, 3'h0, 3'h5};
  logic [1:0] div = 2'h0;
  logic [15:0] a;
  ////////////////////////////////////////////////////////////////////////
  // A floating pin sees the full carrier, a bound one almost none
  always @(negedge clk_i) begin
    div <= div + 2'h1;
    valid_o <= (div == 2'h3);
    for (int i = 0; i < 4; i++) begin
      a = float_i[i] ? 16'h07d0 : 16'h0010;
      smp_o[i] <= drive_i[DRV_MAP[i]] ? base_i + a : base_i - a;
    end
  end
endmodule // lod_electrodes
`default_nettype wire

// ===== test/test_lod_top.sv
// Self-checking bench of the lead-off detector, register port driven.
// Assumes the amplitude window is shortened to 64 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_lod_top;
  import lod_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cal = 1'b0;
  logic frame = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] rdata;
  logic [23:0] d;
  logic rvalid;
  logic svalid;
  logic dc_en;
  logic [2:0] dc_cur;
  logic [5:0] drive;
  logic [1:0] amp;
  lod_mv_t [6:0] mv = {7{12'h514}};
  lod_smp_t [3:0] smp;
  logic [3:0] flt = 4'h0;
  logic [15:0] base = 16'h0000;
  lod_hdr_s hdr;
  int err_count = 0;
  int checks = 0;
  logic [15:0] oor_base [3] = '{16'h5000, 16'hb000, 16'h4000};
  logic oor_exp [3] = '{1'b1, 1'b1, 1'b0};

  always #5 clk = ~clk;

  lod_top #(.WIN_CYCLES(64)) lod_top_i (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .ELEC_MV_I(mv), .ADC_SMP_I(smp),
    .SMP_VALID_I(svalid), .CAL_DAC_EN_I(cal), .FRAME_I(frame),
    .DC_EN_O(dc_en), .DC_CUR_O(dc_cur), .AC_DRIVE_O(drive),
    .AC_AMP_O(amp), .HDR_O(hdr));

  lod_electrodes lod_electrodes_i (
    .clk_i(clk), .drive_i(drive), .float_i(flt), .base_i(base),
    .smp_o(smp), .valid_o(svalid));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [23:0] v);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = v;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Answer comes two edges after the strobe; four is the give-up point
  task automatic rd_reg(input logic [5:0] a);
    int n;
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, rvalid, 1'b1);
      give_verdict();
    end
    d = rdata;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
    rd_reg(a);
    chk(d, exp);
  endtask

  // 200 reads span about ten amplitude windows, the latency limit
  task automatic poll(input logic [3:0] want);
    int n;
    n = 0;
    d = 24'h000000;
    while (d[10:7] !== want && n < 200) begin
      rd_reg(6'h1f);
      n++;
    end
    chk({20'h0, d[10:7]}, {20'h0, want});
  endtask

  task automatic frame_chk(input logic lo, input logic oor);
    @(negedge clk);
    frame = 1'b1;
    @(negedge clk);
    frame = 1'b0;
    @(negedge clk);
    chk({22'h0, hdr}, {22'h0, lo, oor});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd_chk(6'h02, 24'h000000);
    rd_chk(6'h03, 24'h7fffff);
    rd_chk(6'h04, 24'h800000);
    rd_chk(6'h10, 24'h000000);
    wr_reg(6'h1e, 24'hffffff);
    rd_chk(6'h1e, 24'h000000);
    // Codes past the top step clamp to 70 nA
    for (int n = 0; n < 8; n++) begin
      wr_reg(6'h02, {19'h0, 3'(n), 2'b01});
      rd_chk(6'h02, {19'h0, (n > 6) ? 3'h6 : 3'(n), 2'b01});
      chk({20'h0, dc_en, dc_cur}, {20'h0, 1'b1, (n > 6) ? 3'h6 : 3'(n)});
    end
    // Reference output walked in the same loop
    for (int i = 0; i < 7; i++) begin
      mv[i] = (i == 6) ? 12'hbb8 : 12'h9c4;
      rd_chk(6'h1e, 24'h1 << i);
      mv[i] = (i == 6) ? 12'h032 : 12'h096;
      rd_chk(6'h1e, 24'h1 << i);
      mv[i] = 12'h960;
      rd_chk(6'h1e, 24'h000000);
      mv[i] = 12'h0c8;
      rd_chk(6'h1e, 24'h000000);
      mv[i] = 12'h514;
    end
    mv[2] = 12'h9c4;
    rd_chk(6'h1f, 24'h000004);
    frame_chk(1'b1, 1'b0);
    wr_reg(6'h02, 24'h000000);
    rd_chk(6'h1e, 24'h000000);
    frame_chk(1'b0, 1'b0);
    // Host lowers the upper level before arming
    wr_reg(6'h03, 24'h7f000a);
    flt = 4'h1;
    wr_reg(6'h02, 24'h820002);
    rd_chk(6'h1e, 24'h000000);
    chk({22'h0, amp}, 24'h000002);
    chk({23'h0, drive[5] ^ drive[1]}, 24'h000001);
    poll(4'h1);
    rd_reg(6'h31);
    chk({23'h0, d > 24'h00000a}, 24'h000001);
    rd_reg(6'h32);
    chk({23'h0, d < 24'h00000a}, 24'h000001);
    rd_chk(6'h35, 24'h000000);
    frame_chk(1'b1, 1'b0);
    // LA stays above the upper level, the bound three drop below the lower
    wr_reg(6'h04, 24'h800005);
    poll(4'hf);
    // Calibration source parks the ac path and its carrier
    cal = 1'b1;
    repeat (3) @(negedge clk);
    rd_chk(6'h1f, 24'h000000);
    chk({18'h0, drive}, 24'h000000);
    cal = 1'b0;
    poll(4'hf);
    flt = 4'h0;
    wr_reg(6'h02, 24'h000000);
    wr_reg(6'h03, 24'h40000a);
    wr_reg(6'h04, 24'hc00000);
    frame_chk(1'b0, 1'b0);
    // Range hits are kept until the next frame even after the data returns
    for (int k = 0; k < 3; k++) begin
      base = oor_base[k];
      repeat (8) @(negedge clk);
      base = 16'h0000;
      repeat (8) @(negedge clk);
      frame_chk(1'b0, oor_exp[k]);
      repeat (8) @(negedge clk);
      frame_chk(1'b0, 1'b0);
    end
    give_verdict();
  end
endmodule // test_lod_top
`default_nettype wire
